// ==== brwd_top.sv ====
// buffer register window decoder: host window accesses to per-channel buffer commands
// assumes requests synchronous to clk, one per cycle at most; no back-pressure
`timescale 1ns/1ns

module brwd_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire brwd_pkg::brwd_req_s host_req,
  input wire logic base_load,
  input wire logic [brwd_pkg::BASE_W-1:0] base_value,
  input wire logic present_load,
  input wire logic [brwd_pkg::NUM_SLOTS-1:0] present_value,
  output logic host_claim,
  output logic host_drop,
  output logic [brwd_pkg::NUM_CHAN-1:0] chan_cmd_valid,
  output brwd_pkg::brwd_cmd_s chan_cmd,
  output logic [brwd_pkg::BASE_W-1:0] window_region_base,
  output logic [brwd_pkg::NUM_SLOTS-1:0] buffer_present_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic in_window(input logic [brwd_pkg::ADDR_W-1:0] addr,
                                     input logic [brwd_pkg::BASE_W-1:0] base);
    in_window = (addr[brwd_pkg::ADDR_W-1:brwd_pkg::BASE_LSB] == base);
  endfunction

  function automatic logic [brwd_pkg::OFF_W-1:0] window_offset(
      input logic [brwd_pkg::ADDR_W-1:0] addr);
    window_offset = addr[brwd_pkg::OFF_W-1:0];
  endfunction

  function automatic logic [brwd_pkg::CHAN_W-1:0] chan_of(
      input logic [brwd_pkg::OFF_W-1:0] off);
    chan_of = off[brwd_pkg::CHAN_LSB +: brwd_pkg::CHAN_W];
  endfunction

  function automatic logic [brwd_pkg::SLOT_W-1:0] slot_of(
      input logic [brwd_pkg::OFF_W-1:0] off);
    slot_of = off[brwd_pkg::SLOT_LSB +: brwd_pkg::SLOT_W];
  endfunction

  function automatic logic [5:0] slot_index(input logic [brwd_pkg::OFF_W-1:0] off);
    slot_index = {chan_of(off), slot_of(off)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // window settings

  logic [brwd_pkg::BASE_W-1:0] next_window_region_base;
  logic [brwd_pkg::NUM_SLOTS-1:0] next_buffer_present_bits;

  always_comb begin
    next_window_region_base = window_region_base;
    next_buffer_present_bits = buffer_present_bits;
    // RULE10 relocatable base
    if (base_load) begin
      next_window_region_base = base_value;
    end
    // RULE9 present bits load
    if (present_load) begin
      next_buffer_present_bits = present_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      window_region_base <= brwd_pkg::BASE_RESET;
      buffer_present_bits <= brwd_pkg::PRESENT_RESET;
    end else begin
      window_region_base <= next_window_region_base;
      buffer_present_bits <= next_buffer_present_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic req_hit;
  logic [brwd_pkg::OFF_W-1:0] req_off;
  logic req_present;
  logic next_host_claim;
  logic next_host_drop;
  logic [brwd_pkg::NUM_CHAN-1:0] next_chan_cmd_valid;
  brwd_pkg::brwd_cmd_s next_chan_cmd;

  always_comb begin
    // RULE2 RULE11 base-relative 128 KB match
    req_hit = host_req.valid && in_window(host_req.addr, window_region_base);
    req_off = window_offset(host_req.addr);
    // RULE9 present gate
    req_present = buffer_present_bits[slot_index(req_off)];
    // RULE12 claim only inside window
    next_host_claim = req_hit;
    next_host_drop = req_hit && !req_present;
    next_chan_cmd_valid = '0;
    // RULE3 RULE5 RULE6 RULE7 RULE8 channel select
    if (req_hit && req_present) begin
      next_chan_cmd_valid[chan_of(req_off)] = 1'h1;
    end
    next_chan_cmd = chan_cmd;
    if (req_hit && req_present) begin
      next_chan_cmd.write = host_req.write;
      // RULE1 2 KB slot per buffer chip
      next_chan_cmd.slot = slot_of(req_off);
      // RULE4 function above register offset
      next_chan_cmd.func = req_off[brwd_pkg::FUNC_LSB +: brwd_pkg::FUNC_W];
      next_chan_cmd.reg_off = req_off[brwd_pkg::REG_LSB +: brwd_pkg::REG_W];
      next_chan_cmd.wdata = host_req.wdata;
    end
  end

  // RULE3 one-cycle answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_claim <= 1'h0;
      host_drop <= 1'h0;
      chan_cmd_valid <= '0;
      chan_cmd <= '0;
    end else begin
      host_claim <= next_host_claim;
      host_drop <= next_host_drop;
      chan_cmd_valid <= next_chan_cmd_valid;
      chan_cmd <= next_chan_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic req_go;
  assign req_go = req_hit && req_present;

  a_slot_stride: assert property ( // RULE1
    req_go |=> chan_cmd.slot == 4'(($past(req_off) % brwd_pkg::CHAN_BYTES)
                                   / brwd_pkg::SLOT_BYTES))
    else $error("slot not picked by 2 KB stride");

  a_claim_base: assert property ( // RULE2
    host_req.valid && host_req.addr[39:17] == window_region_base |=> host_claim)
    else $error("window access not claimed");

  a_send_present: assert property ( // RULE3
    req_go |=> $onehot(chan_cmd_valid) && !host_drop)
    else $error("present slot got no single command");

  a_func_offset: assert property ( // RULE4
    req_go |=> {chan_cmd.func, chan_cmd.reg_off} == $past(host_req.addr[10:0])
               && chan_cmd.write == $past(host_req.write))
    else $error("function or register offset wrong");

  a_chan_zero: assert property ( // RULE5
    req_go && req_off < brwd_pkg::CHAN_BYTES |=> chan_cmd_valid == 4'h1)
    else $error("low quarter not on channel 0");

  a_chan_one: assert property ( // RULE6
    req_go && req_off >= 17'h08000 && req_off <= 17'h0ffff |=> chan_cmd_valid == 4'h2)
    else $error("second quarter not on channel 1");

  a_chan_two: assert property ( // RULE7
    req_go && req_off >= 17'h10000 && req_off <= 17'h17fff |=> chan_cmd_valid == 4'h4)
    else $error("third quarter not on channel 2");

  a_chan_three: assert property ( // RULE8
    req_go && req_off >= 17'h18000 |=> chan_cmd_valid == 4'h8)
    else $error("top quarter not on channel 3");

  a_absent_silent: assert property ( // RULE9
    req_hit && !req_present |=> chan_cmd_valid == 4'h0 && host_drop)
    else $error("command sent to absent slot");

  a_base_write: assert property ( // RULE10
    base_load |=> window_region_base == $past(base_value) ##1
      ($past(base_load) || window_region_base == $past(window_region_base)))
    else $error("base not loaded or not held");

  a_window_size: assert property ( // RULE11
    host_req.valid && host_req.addr[39:17] == window_region_base
      && host_req.addr[16:0] == brwd_pkg::WINDOW_BYTES |=> host_claim)
    else $error("last window byte not claimed");

  a_outside_quiet: assert property ( // RULE12
    !req_hit |=> !host_claim && chan_cmd_valid == 4'h0 && !host_drop)
    else $error("outside access claimed");

  a_valid_onehot: assert property ( // RULE3
    $onehot0(chan_cmd_valid))
    else $error("more than one channel commanded");

  a_wdata_pass: assert property ( // RULE3
    req_go |=> chan_cmd.wdata == $past(host_req.wdata))
    else $error("write data not carried");

  a_cmd_hold: assert property ( // RULE9
    !req_go |=> $stable(chan_cmd))
    else $error("command changed without a send");

  a_present_load: assert property ( // RULE9
    present_load |=> buffer_present_bits == $past(present_value))
    else $error("present bits not loaded");

  a_present_hold: assert property ( // RULE9
    !present_load |=> $stable(buffer_present_bits))
    else $error("present bits changed without load");

  a_base_hold: assert property ( // RULE10
    !base_load |=> $stable(window_region_base))
    else $error("base changed without load");

  a_drop_claim: assert property ( // RULE12
    host_drop |-> host_claim)
    else $error("drop flagged on unclaimed access");

  c_send_each: cover property (req_go ##1 req_go);
  c_drop: cover property (req_hit && !req_present);
  c_relocate_hit: cover property (base_load ##1 req_go);
  c_top_slot: cover property (req_go && slot_index(req_off) == 6'h3f);
  c_read_send: cover property (req_go && !host_req.write);

endmodule // brwd_top

// ==== brwd_pkg.sv ====
// constants and carriers for the buffer register window decoder
// assumes one hub core clock; host accesses arrive already as single requests
// Function
// RULE1: window is cut into consecutive 2 KB slots, one buffer chip per slot
// RULE2: window sits at the programmable region base, offsets decoded relative to it
// RULE3: in-slot access becomes a channel command only when its present bit is set
// RULE4: slot offset is 3-bit function above 8-bit register offset, 11 bits total
// RULE5: offsets 0h to 7FFFh go to channel 0, slots ascending by 800h
// RULE6: offsets 8000h to FFFFh go to channel 1, slots ascending by 800h
// RULE7: offsets 10000h to 17FFFh go to channel 2, slots ascending by 800h
// RULE8: offsets 18000h to 1FFFFh go to channel 3, slots ascending by 800h
// RULE9: a slot with its present bit clear gets no command at all
// RULE10: base is a writable field on address bits 39:17, default 0xFE00_0000
// RULE11: window spans 128 KB, 32 KB for each of four channels
// RULE12: accesses outside are not claimed; channel 16:15, slot 14:11, function 10:8
package brwd_pkg;

  localparam int ADDR_W = 40;
  localparam int DATA_W = 32;
  localparam int BASE_LSB = 17;
  localparam int BASE_W = ADDR_W - BASE_LSB;
  localparam logic [BASE_W-1:0] BASE_RESET = 23'h007f00;
  localparam logic [63:0] PRESENT_RESET = 64'h0000000000000000;

  localparam int OFF_W = BASE_LSB;
  localparam logic [OFF_W-1:0] WINDOW_BYTES = 17'h1ffff;
  localparam logic [OFF_W-1:0] CHAN_BYTES = 17'h08000;
  localparam logic [OFF_W-1:0] SLOT_BYTES = 17'h00800;
  localparam int NUM_CHAN = 4;
  localparam int SLOTS_PER_CHAN = 16;
  localparam int NUM_SLOTS = NUM_CHAN * SLOTS_PER_CHAN;

  localparam int CHAN_LSB = 15;
  localparam int CHAN_W = 2;
  localparam int SLOT_LSB = 11;
  localparam int SLOT_W = 4;
  localparam int FUNC_LSB = 8;
  localparam int FUNC_W = 3;
  localparam int REG_LSB = 0;
  localparam int REG_W = 8;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } brwd_req_s;

  typedef struct packed {
    logic write;
    logic [SLOT_W-1:0] slot;
    logic [FUNC_W-1:0] func;
    logic [REG_W-1:0] reg_off;
    logic [DATA_W-1:0] wdata;
  } brwd_cmd_s;

endpackage

// ==== brwd_buf_model.sv ====
// partner model: the buffer chips behind the four channels
// assumes chan_cmd_valid is a one-cycle one-hot pulse per command
`timescale 1ns/1ns

module brwd_buf_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] cmd_valid,
  input wire brwd_pkg::brwd_cmd_s cmd,
  output logic [7:0] cmd_count,
  output logic [63:0] hit_map
);
  // counts commands; each chip marks its own bit, index channel*16 + slot
  always @(posedge clk) begin
    if (!reset_n) begin
      cmd_count <= 8'h00;
      hit_map <= 64'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (cmd_valid[c]) begin
          cmd_count <= cmd_count + 8'h01;
          hit_map[{c[1:0], cmd.slot}] <= 1'h1;
        end
      end
    end
  end
endmodule // brwd_buf_model

// ==== tb.sv ====
// self-checking testbench for the window decoder
// assumes brwd_pkg and brwd_buf_model compiled first
`timescale 1ns/1ns

module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic base_load = 1'b0;
  logic present_load = 1'b0;
  logic [22:0] base_value = 23'h0;
  logic [63:0] present_value = 64'h0;
  brwd_pkg::brwd_req_s host_req = '0;
  logic host_claim;
  logic host_drop;
  logic [3:0] chan_cmd_valid;
  brwd_pkg::brwd_cmd_s chan_cmd;
  logic [22:0] window_region_base;
  logic [63:0] buffer_present_bits;
  logic [7:0] cmd_count;
  logic [63:0] hit_map;
  int fail_count = 0;
  int num_checks = 0;

  brwd_top u_brwd_top (.clk(clk), .reset_n(reset_n), .host_req(host_req),
    .base_load(base_load), .base_value(base_value), .present_load(present_load),
    .present_value(present_value), .host_claim(host_claim), .host_drop(host_drop),
    .chan_cmd_valid(chan_cmd_valid), .chan_cmd(chan_cmd),
    .window_region_base(window_region_base), .buffer_present_bits(buffer_present_bits));
  brwd_buf_model u_brwd_buf_model (.clk(clk), .reset_n(reset_n), .cmd_valid(chan_cmd_valid),
    .cmd(chan_cmd), .cmd_count(cmd_count), .hit_map(hit_map));

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic go(input logic w, input logic [39:0] a);
    @(posedge clk);
    host_req <= {1'b1, w, a, 32'hc3a50f1e};
    @(posedge clk);
    host_req.valid <= 1'b0;
    #1;
  endtask

  task automatic ld(input logic [22:0] b, input logic [63:0] p);
    @(posedge clk);
    base_value <= b;
    present_value <= p;
    base_load <= 1'b1;
    present_load <= 1'b1;
    @(posedge clk);
    base_load <= 1'b0;
    present_load <= 1'b0;
    #1;
  endtask

  task automatic ans(input logic c, input logic d, input logic [3:0] v);
    chk(host_claim, c);
    chk(host_drop, d);
    chk(chan_cmd_valid, v);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    chk(window_region_base, brwd_pkg::BASE_RESET);
    chk(buffer_present_bits, 64'h0);
    go(1'b1, {brwd_pkg::BASE_RESET, 17'h09a05});
    ans(1'b1, 1'b1, 4'h0);
    $display("t_reset done");
  endtask

  task automatic t_map;
    logic [2:0] f;
    logic [7:0] r;
    ld(brwd_pkg::BASE_RESET, ~64'h0);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 16; s += 15) begin
        f = 3'(c + s);
        r = {8{s[0]}};
        // slot 15 writes, slot 0 reads
        go(s[0], {brwd_pkg::BASE_RESET, c[1:0], s[3:0], f, r});
        ans(1'b1, 1'b0, 4'h1 << c);
        chk(chan_cmd.slot, s[3:0]);
        chk({chan_cmd.func, chan_cmd.reg_off}, {f, r});
        chk({chan_cmd.write, chan_cmd.wdata}, {s[0], 32'hc3a50f1e});
      end
    end
    @(posedge clk);
    #1;
    chk(hit_map, 64'h8001800180018001);
    $display("t_map done");
  endtask

  task automatic t_move;
    ld(23'h000123, ~(64'h1 << 19));
    chk(window_region_base, 23'h000123);
    chk(buffer_present_bits, ~(64'h1 << 19));
    go(1'b1, {23'h000123, 17'h09a05});
    ans(1'b1, 1'b1, 4'h0);
    go(1'b1, {23'h000123, 17'h1ffff});
    ans(1'b1, 1'b0, 4'h8);
    chk({chan_cmd.slot, chan_cmd.func, chan_cmd.reg_off}, 15'h7fff);
    go(1'b1, {23'h000124, 17'h00000});
    ans(1'b0, 1'b0, 4'h0);
    go(1'b1, {brwd_pkg::BASE_RESET, 17'h00000});
    ans(1'b0, 1'b0, 4'h0);
    chk(cmd_count, 8'h09);
    $display("t_move done");
  endtask

  task automatic t_burst;
    // base load beside a request: old base decodes it, next request uses new base
    @(posedge clk);
    base_value <= brwd_pkg::BASE_RESET;
    base_load <= 1'h1;
    host_req <= {1'h1, 1'h0, 23'h000123, 17'h08800, 32'h00005a5a};
    @(posedge clk);
    base_load <= 1'h0;
    host_req <= {1'h1, 1'h1, brwd_pkg::BASE_RESET, 17'h10000, 32'h00005a5a};
    #1;
    ans(1'h1, 1'h0, 4'h2);
    chk({chan_cmd.write, chan_cmd.slot}, 5'h01);
    @(posedge clk);
    host_req.valid <= 1'h0;
    #1;
    ans(1'h1, 1'h0, 4'h4);
    chk({chan_cmd.write, chan_cmd.slot, chan_cmd.wdata}, 37'h1000005a5a);
    go(1'h0, {brwd_pkg::BASE_RESET, 17'h09a05});
    ans(1'h1, 1'h1, 4'h0);
    chk({chan_cmd.write, chan_cmd.slot, chan_cmd.wdata}, 37'h1000005a5a);
    chk(cmd_count, 8'h0b);
    chk(hit_map, 64'h8001800180038001);
    $display("t_burst done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_map();
    t_move();
    t_burst();
    end_sim();
  end
endmodule // tb
